// ---- etc_pkg.sv ----
// Package: register map, field positions and reset values of the 8-bit timer/counter
package etc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [3:0] ADDR_COUNT = 4'h0;
  localparam logic [3:0] ADDR_OPTION = 4'h1;
  localparam logic [3:0] ADDR_INTCTL = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_MASK = 4'h4;
  // Option register fields
  localparam int OPT_PS_LSB = 0;
  localparam int OPT_PS_W = 3;
  localparam int OPT_PSA_BIT = 3;
  localparam int OPT_EDGE_BIT = 4;
  localparam int OPT_CS_BIT = 5;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] OPTION_WMASK = 8'h3F;
  // Interrupt control register fields
  localparam int INTCTL_FLAG_BIT = 2;
  localparam int INTCTL_EN_BIT = 5;
  localparam logic [7:0] INTCTL_WMASK = 8'h24;
  // Event status bits
  localparam int EV_OVF_BIT = 0;
  localparam int EV_WRITE_BIT = 1;
  localparam int EV_W = 2;
  // Timing
  localparam int WRITE_HOLD_CYC = 2;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] ZERO8 = 8'h00;
endpackage : etc_pkg

// ---- etc_timer.sv ----
// Module: 8-bit timer/counter with shared prescaler and overflow interrupt
//
// Function
// - Option bit 5 clear selects timer mode, counting instruction cycles.
// - Timer mode without prescaler advances the count every instruction cycle.
// - A write to the count register holds off incrementing for the next two instruction cycles.
// - Option bit 5 set selects counter mode, counting the external count pin.
// - Option bit 4 picks the counting edge: zero rising, one falling.
// - Option bit 3 gives the one prescaler to the counter when zero, to the watchdog when one.
// - The prescaler count can be neither read nor written by software.
// - When assigned to the counter the prescaler divides by 2 to 256 in powers of two.
// - Rollover from FFh to 00h sets the overflow flag, bit 2 of interrupt control.
// - The overflow interrupt is suppressed while enable bit 5 of interrupt control is zero.
// - During sleep the counter stops, so overflow cannot wake the core.
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module etc_timer #(
  parameter int PRESCALE_W = 8
) (
  input wire logic ref_clk_i, // 50 MHz instruction-cycle clock
  input wire logic reset_n_i, // Asynchronous reset, active low
  input wire logic [etc_pkg::ADDR_W-1:0] addr_i, // Register address
  input wire logic [etc_pkg::DATA_W-1:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [etc_pkg::DATA_W-1:0] rdata_o, // Read data, cycle after read
  input wire logic sleep_i, // Core in sleep
  input wire logic external_count_pin_i, // External count pin, asynchronous
  output logic watchdog_tick_o, // Prescaled tick when prescaler given to watchdog
  input wire logic watchdog_tick_i, // Watchdog timebase input to prescaler
  output logic overflow_irq_o, // Overflow interrupt request
  output logic irq_o // Masked event interrupt, level
);

  // Elaboration checks: select field, hold counter and event bits are sized for these values
  if (PRESCALE_W != 8) begin : g_bad_prescale_w
    $error("etc_timer: prescaler must be 8 bits wide");
  end
  if (etc_pkg::WRITE_HOLD_CYC < 1 || etc_pkg::WRITE_HOLD_CYC > 3) begin : g_bad_hold
    $error("etc_timer: write hold-off must fit the 2-bit hold counter");
  end
  if (etc_pkg::OPT_PS_W != 3) begin : g_bad_sel
    $error("etc_timer: prescale select must be 3 bits");
  end
  if (etc_pkg::EV_OVF_BIT >= etc_pkg::EV_W || etc_pkg::EV_WRITE_BIT >= etc_pkg::EV_W) begin : g_bad_ev
    $error("etc_timer: event bit outside the status register");
  end
  if (etc_pkg::ADDR_W != 4) begin : g_bad_addr
    $error("etc_timer: register offsets need a 4-bit address");
  end
  if (etc_pkg::OPT_CS_BIT >= etc_pkg::DATA_W) begin : g_bad_cs
    $error("etc_timer: option field outside the register");
  end

  // Pin synchroniser and edge detect
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_d_r;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= external_count_pin_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Edge history; resets to the pin's idle low level so no false edge follows reset
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_d_r <= 1'b0;
    end else begin
      pin_d_r <= pin_s2_r;
    end
  end

  // Software-visible registers
  logic [7:0] count_register_r;
  logic [7:0] option_r;
  logic overflow_flag_r;
  logic overflow_int_enable_r;

  // Event status and its mask
  logic [etc_pkg::EV_W-1:0] status_r;
  logic [etc_pkg::EV_W-1:0] mask_r;

  // Hidden state: write hold-off and the prescaler, which software never reaches
  logic [1:0] hold_r;
  logic [PRESCALE_W-1:0] prescale_r;

  // Single bit of the option register
  function automatic logic opt_bit(input logic [7:0] opt, input int pos);
    return opt[pos];
  endfunction : opt_bit

  // Option field decode
  logic clock_source_select;
  logic edge_select;
  logic prescaler_assignment;

  assign clock_source_select = opt_bit(option_r, etc_pkg::OPT_CS_BIT);
  assign edge_select = opt_bit(option_r, etc_pkg::OPT_EDGE_BIT);
  assign prescaler_assignment = opt_bit(option_r, etc_pkg::OPT_PSA_BIT);

  // Strobe qualified by a register address
  function automatic logic reg_hit(
    input logic strobe,
    input logic [etc_pkg::ADDR_W-1:0] addr,
    input logic [etc_pkg::ADDR_W-1:0] target
  );
    return strobe && (addr == target);
  endfunction : reg_hit

  logic wr_count;
  logic wr_option;
  logic wr_intctl;
  logic wr_mask;
  logic rd_status;

  assign wr_count = reg_hit(wr_i, addr_i, etc_pkg::ADDR_COUNT);
  assign wr_option = reg_hit(wr_i, addr_i, etc_pkg::ADDR_OPTION);
  assign wr_intctl = reg_hit(wr_i, addr_i, etc_pkg::ADDR_INTCTL);
  assign wr_mask = reg_hit(wr_i, addr_i, etc_pkg::ADDR_MASK);
  assign rd_status = reg_hit(rd_i, addr_i, etc_pkg::ADDR_STATUS);

  // Source event selection
  // Edges come from the synchronised pin and its one-cycle history
  logic rise_ev;
  logic fall_ev;
  logic src_ev;
  assign rise_ev = pin_s2_r && !pin_d_r;
  assign fall_ev = !pin_s2_r && pin_d_r;
  always_comb begin
    if (clock_source_select) begin
      src_ev = edge_select ? fall_ev : rise_ev;
    end else begin
      src_ev = 1'b1;
    end
  end

  // Sleep freezes the counter path; the watchdog timebase keeps running
  // so the watchdog can still end a sleep through its own prescaled tick
  logic run_en;
  assign run_en = !sleep_i;

  // Prescaler input is the counter source or the watchdog timebase
  logic ps_in;
  assign ps_in = prescaler_assignment ? watchdog_tick_i : (src_ev && run_en);

  // Prescale period done when the selected low bits all wrap; select n divides by 2 to the power n+1
  function automatic logic ps_done(
    input logic [PRESCALE_W-1:0] cnt,
    input logic [etc_pkg::OPT_PS_W-1:0] sel
  );
    logic [PRESCALE_W-1:0] lim;
    lim = PRESCALE_W'((1 << (sel + 1)) - 1);
    return (cnt & lim) == lim;
  endfunction : ps_done

  logic [etc_pkg::OPT_PS_W-1:0] ps_sel;
  assign ps_sel = option_r[etc_pkg::OPT_PS_LSB +: etc_pkg::OPT_PS_W];

  logic ps_tick;
  assign ps_tick = ps_in && ps_done(prescale_r, ps_sel);

  // Prescaler count, no software path; cleared when count is written under counter assignment
  // Clearing on a count write restarts the period so the written value lasts a full period
  // Advances only on prescaler input events (counter source or watchdog timebase) and wraps at the end of each period
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prescale_r <= '0;
    end else if (wr_count && !prescaler_assignment) begin
      prescale_r <= '0;
    end else if (ps_in) begin
      prescale_r <= ps_tick ? '0 : prescale_r + 1'b1;
    end
  end

  // Prescaled tick handed to the watchdog only while it owns the prescaler
  assign watchdog_tick_o = prescaler_assignment && ps_tick;

  // Counter step: raw source without the prescaler, prescaled tick with it
  logic cnt_step;
  always_comb begin
    if (prescaler_assignment) begin
      cnt_step = src_ev;
    end else begin
      cnt_step = ps_tick;
    end
  end

  // Write hold-off still running
  logic hold_busy;
  assign hold_busy = (hold_r != 2'h0);

  // A write in the same cycle wins over an increment; sleep blocks every step
  logic cnt_inc;
  logic cnt_wrap;
  assign cnt_inc = cnt_step && run_en && !hold_busy && !wr_count;
  assign cnt_wrap = cnt_inc && (count_register_r == etc_pkg::COUNT_MAX);

  // Write hold-off
  // Loaded on a count write, then counts down to zero
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_r <= 2'h0;
    end else if (wr_count) begin
      hold_r <= 2'(etc_pkg::WRITE_HOLD_CYC);
    end else if (hold_busy) begin
      hold_r <= hold_r - 2'h1;
    end
  end

  // Count register
  // The count simply wraps and keeps running after FFh
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_register_r <= etc_pkg::COUNT_RST;
    end else if (wr_count) begin
      count_register_r <= wdata_i;
    end else if (cnt_inc) begin
      count_register_r <= count_register_r + 8'h01;
    end
  end

  // Option register
  // Bits 7:6 are not writable and read as one
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      option_r <= etc_pkg::OPTION_RST;
    end else if (wr_option) begin
      option_r <= (option_r & ~etc_pkg::OPTION_WMASK) | (wdata_i & etc_pkg::OPTION_WMASK);
    end
  end

  // Overflow flag: a rollover in the same cycle as a software clear wins
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      overflow_flag_r <= 1'b0;
    end else if (cnt_wrap) begin
      overflow_flag_r <= 1'b1;
    end else if (wr_intctl) begin
      overflow_flag_r <= wdata_i[etc_pkg::INTCTL_FLAG_BIT];
    end
  end

  // Overflow interrupt enable
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      overflow_int_enable_r <= 1'b0;
    end else if (wr_intctl) begin
      overflow_int_enable_r <= wdata_i[etc_pkg::INTCTL_EN_BIT];
    end
  end

  // Overflow request is a level that follows flag and enable
  assign overflow_irq_o = overflow_flag_r && overflow_int_enable_r;

  // Sticky event status, cleared by reading it
  // Read clear keeps an event that lands in the same cycle as the read
  logic [etc_pkg::EV_W-1:0] ev_set;
  always_comb begin
    ev_set = '0;
    ev_set[etc_pkg::EV_OVF_BIT] = cnt_wrap;
    ev_set[etc_pkg::EV_WRITE_BIT] = wr_count;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_r <= '0;
    end else if (rd_status) begin
      status_r <= ev_set;
    end else begin
      status_r <= status_r | ev_set;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_r <= '0;
    end else if (wr_mask) begin
      mask_r <= wdata_i[etc_pkg::EV_W-1:0];
    end
  end

  // Level request while any unmasked status bit is set
  assign irq_o = |(status_r & mask_r);

  // Register images as software reads them; unused bits read zero
  function automatic logic [7:0] intctl_image(input logic flag, input logic enable);
    logic [7:0] img;
    img = etc_pkg::ZERO8;
    img[etc_pkg::INTCTL_FLAG_BIT] = flag;
    img[etc_pkg::INTCTL_EN_BIT] = enable;
    return img;
  endfunction : intctl_image

  // Event bits placed at the bottom of a byte
  function automatic logic [7:0] event_image(input logic [etc_pkg::EV_W-1:0] ev);
    logic [7:0] img;
    img = etc_pkg::ZERO8;
    img[etc_pkg::EV_W-1:0] = ev;
    return img;
  endfunction : event_image

  // Read data, one cycle after strobe
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = etc_pkg::ZERO8;
    case (addr_i)
      etc_pkg::ADDR_COUNT: begin
        rd_mux = count_register_r;
      end
      etc_pkg::ADDR_OPTION: begin
        rd_mux = option_r;
      end
      etc_pkg::ADDR_INTCTL: begin
        rd_mux = intctl_image(overflow_flag_r, overflow_int_enable_r);
      end
      etc_pkg::ADDR_STATUS: begin
        rd_mux = event_image(status_r);
      end
      etc_pkg::ADDR_MASK: begin
        rd_mux = event_image(mask_r);
      end
      default: begin
        rd_mux = etc_pkg::ZERO8;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= etc_pkg::ZERO8;
    end else if (rd_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= etc_pkg::ZERO8;
    end
  end

endmodule : etc_timer

// ---- etc_timer_monitor.sv ----
// Checker for the timer/counter register port and interrupts
`timescale 1ns/100ps
module etc_timer_monitor #(
  parameter int PRESCALE_W = 8
) (
  input wire logic ref_clk_i, // Clock
  input wire logic reset_n_i, // Reset, active low
  input wire logic [etc_pkg::ADDR_W-1:0] addr_i, // Address
  input wire logic [etc_pkg::DATA_W-1:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  input wire logic [etc_pkg::DATA_W-1:0] rdata_o, // Read data
  input wire logic overflow_irq_o, // Overflow request
  input wire logic irq_o // Event request
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence wr_at(logic [3:0] a);
    wr_i && addr_i == a;
  endsequence
  sequence rd_at(logic [3:0] a);
    rd_i && addr_i == a;
  endsequence
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not idle");
  chk_unmapped_zero: assert property (rd_i && addr_i > 4'h4 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_opt_fixed: assert property (rd_at(etc_pkg::ADDR_OPTION) |=> rdata_o[7:6] == 2'h3)
    else $error("option top bits wrong");
  chk_opt_write: assert property (wr_at(etc_pkg::ADDR_OPTION) ##2 rd_at(etc_pkg::ADDR_OPTION)
    |=> rdata_o == (($past(wdata_i, 3) & etc_pkg::OPTION_WMASK) | 8'hC0)) else $error("option readback wrong");
  chk_intctl_bits: assert property (rd_at(etc_pkg::ADDR_INTCTL) |=> (rdata_o & ~etc_pkg::INTCTL_WMASK) == 8'h00)
    else $error("interrupt control spare bits set");
  chk_ovf_gate: assert property (rd_at(etc_pkg::ADDR_INTCTL)
    |=> $past(overflow_irq_o) == (rdata_o[5] && rdata_o[2])) else $error("overflow request not flag and enable");
  chk_count_hold: assert property (wr_at(etc_pkg::ADDR_COUNT) ##2 rd_at(etc_pkg::ADDR_COUNT)
    |=> rdata_o == $past(wdata_i, 3)) else $error("count moved during hold");
  chk_ovf_sticky: assert property ($fell(overflow_irq_o) |-> $past(wr_i && addr_i == etc_pkg::ADDR_INTCTL))
    else $error("overflow flag cleared by hardware");
  chk_irq_fall: assert property ($fell(irq_o) |-> $past(rd_i && addr_i == etc_pkg::ADDR_STATUS
    || wr_i && addr_i == etc_pkg::ADDR_MASK)) else $error("event request dropped without access");
endmodule : etc_timer_monitor
bind etc_timer etc_timer_monitor #(.PRESCALE_W(PRESCALE_W)) etc_timer_monitor_i (.ref_clk_i(ref_clk_i),
  .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .overflow_irq_o(overflow_irq_o), .irq_o(irq_o));

// ---- etc_pin_model.sv ----
// Model of the external count pin source
`timescale 1ns/100ps
module etc_pin_model (
  output logic pin_o // External count pin level
);
  initial pin_o = 1'h0;
  // Level change after a lag, prompt or slow
  task automatic drive(input logic lvl, input int lag_ns);
    #(lag_ns);
    pin_o = lvl;
  endtask : drive
endmodule : etc_pin_model

// ---- etc_timer_tb.sv ----
// Testbench for the 8-bit timer/counter
`timescale 1ns/100ps
module etc_timer_tb;
  logic ref_clk_i, reset_n_i, wr_i, rd_i, sleep_i, pin, overflow_irq_o, irq_o, wd_in, wd_out;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o, v, w;
  int num_errors = 0;
  int n_tests = 0;
  etc_timer etc_timer_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i), .external_count_pin_i(pin),
    .watchdog_tick_o(wd_out), .watchdog_tick_i(wd_in), .overflow_irq_o(overflow_irq_o), .irq_o(irq_o));
  etc_pin_model etc_pin_model_i (.pin_o(pin));
  initial begin
    ref_clk_i = 1'h0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge ref_clk_i);
    wr_i <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge ref_clk_i);
    rd_i <= 1'h0;
    #1 d = rdata_o;
  endtask : rd
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    rd(a, v);
    chk(v, exp);
  endtask : rdc
  task automatic t_reset();
    for (int i = 7; i >= 0; i--) rdc(4'(i % 5), (i % 5 == 1) ? 8'hFF : 8'h00);
    wr(4'h9, 8'h5A);
    rdc(4'h9, 8'h00);
    wr(4'h1, 8'h08);
    rdc(4'h1, 8'hC8);
  endtask : t_reset
  task automatic t_timer();
    wr(4'h0, 8'h10);
    rdc(4'h0, 8'h10);
    rdc(4'h0, 8'h11);
    rdc(4'h0, 8'h13);
  endtask : t_timer
  task automatic t_ovf();
    wr(4'h4, 8'h01);
    wr(4'h2, 8'h00);
    wr(4'h0, 8'hFE);
    repeat (8) @(posedge ref_clk_i);
    #1 chk(irq_o, 8'h01);
    chk(overflow_irq_o, 8'h00);
    rdc(4'h2, 8'h04);
    rdc(4'h3, 8'h03);
    chk(irq_o, 8'h00);
    wr(4'h2, 8'h24);
    #1 chk(overflow_irq_o, 8'h01);
    wr(4'h2, 8'h20);
    #1 chk(overflow_irq_o, 8'h00);
  endtask : t_ovf
  task automatic t_sleep();
    wr(4'h0, 8'h40);
    sleep_i <= 1'h1;
    repeat (10) @(posedge ref_clk_i);
    rdc(4'h0, 8'h40);
    sleep_i <= 1'h0;
  endtask : t_sleep
  task automatic t_presc();
    for (int p = 0; p < 8; p++) begin
      wr(4'h1, 8'(p));
      rd(4'h0, v);
      repeat ((4 << p) - 2) @(posedge ref_clk_i);
      rd(4'h0, w);
      chk(w - v, 8'h02);
    end
  endtask : t_presc
  task automatic t_count();
    for (int i = 0; i < 2; i++) begin
      wr(4'h1, (i == 0) ? 8'h28 : 8'h38);
      rd(4'h0, v);
      etc_pin_model_i.drive(1'h1, 3);
      repeat (6) @(posedge ref_clk_i);
      rd(4'h0, w);
      chk(w - v, (i == 0) ? 8'h01 : 8'h00);
      etc_pin_model_i.drive(1'h0, 15);
      repeat (6) @(posedge ref_clk_i);
      rd(4'h0, v);
      chk(v - w, (i == 0) ? 8'h00 : 8'h01);
    end
  endtask : t_count
  task automatic t_wdog();
    int k;
    k = 0;
    @(posedge ref_clk_i);
    wd_in <= 1'h1;
    repeat (8) begin
      @(posedge ref_clk_i);
      #1 k += int'(wd_out);
    end
    @(posedge ref_clk_i);
    wd_in <= 1'h0;
    chk(8'(k), 8'h04);
  endtask : t_wdog
  task automatic conclude();
    $display("Tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  initial begin
    {reset_n_i, wr_i, rd_i, sleep_i, wd_in, addr_i, wdata_i} = '0;
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'h1;
    t_reset();
    t_timer();
    t_ovf();
    t_sleep();
    t_presc();
    t_count();
    t_wdog();
    conclude();
  end
  // Tests need about 1200 cycles; this allows well over that
  initial begin
    #200000;
    num_errors++;
    conclude();
  end
endmodule : etc_timer_tb
